// ---- logic/ppm_pkg.sv ----
// Types for the program page mapper.
// Assumes the constants header sits beside it.
`include "ppm_regs.svh"
package ppm_pkg;
  typedef logic [`PPM_PC_WIDTH-1:0] ppm_pc_t;
  typedef logic [1:0] ppm_page_t;

  // Data-space write from the core
  typedef struct packed {
    logic valid;
    logic [7:0] addr;
    logic [7:0] data;
  } ppm_dwrite_t;

  // Stack operations
  typedef enum logic [1:0] {
    PPM_STK_NONE = 2'b00,
    PPM_STK_PUSH = 2'b01,
    PPM_STK_POP = 2'b10
  } ppm_stk_op_t;

  // Whole module state
  typedef struct packed {
    ppm_page_t pageSelect;
    logic [`PPM_PHYS_WIDTH-1:0] physAddr;
    logic fetchValid;
    logic [2:0] stackCount;
    logic [`PPM_STACK_DEPTH-1:0][`PPM_PC_WIDTH-1:0] stack;
  } ppm_state_t;
endpackage

// ---- logic/ppm_program_page_mapper.sv ----
// Program-space page mapper: 12-bit fetch address to 13-bit memory address,
// page-select register in data space, six-level return stack.
// Assumes the core presents fetches and data writes synchronous to clk.
`timescale 1ns/1ps
`include "ppm_regs.svh"

// Operation
// - Fetch addresses are 12 bits wide.
// - Memory is four 2-Kbyte pages with page 1 as the static page.
// - Addresses with bit 11 set always reach the static page.
// - Addresses with bit 11 clear reach the page held in the select register.
// - The static page is also reachable through the lower range.
// - The select register sits at data address CAh and is write only.
// - A write loads the page number used by later lower-range fetches.
// - Calls, returns and interrupts leave the select register unchanged.
// - The static page holds the interrupt, NMI and reset vectors.
// - A separate six-level stack keeps return addresses.
// - The page number is bits 1-0 of the select register.
// - The select register is undefined after reset; the code loads it with zero.
module ppm_program_page_mapper
  import ppm_pkg::*;
#(
  parameter int STACK_DEPTH = `PPM_STACK_DEPTH
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fetchReq,
  input wire ppm_pc_t fetchPc,
  input wire ppm_dwrite_t dataWrite,
  input wire ppm_stk_op_t stackOp,
  input wire ppm_pc_t stackPushPc,
  output logic [`PPM_PHYS_WIDTH-1:0] memAddr,
  output logic memValid,
  output logic vectorHit,
  output ppm_pc_t stackTop,
  output logic stackFull,
  output logic stackEmpty
);

  // ****************************************
  // State
  // ****************************************
  ppm_state_t state;
  ppm_state_t next_state;
  ppm_page_t effPage;
  logic selWrite;

  // Page choice; static page wins whenever PC bit 11 is high
  always_comb
  begin
    selWrite = dataWrite.valid && (dataWrite.addr == `PPM_PAGE_SELECT_ADDR);
    if (fetchPc[`PPM_PAGE_BIT])
      effPage = `PPM_STATIC_PAGE;
    else
      effPage = state.pageSelect;
  end

  // ****************************************
  // Next state
  // ****************************************
  // Stack never touches pageSelect, so calls cannot corrupt the mapping
  always_comb
  begin
    next_state = state;
    next_state.fetchValid = fetchReq;
    if (fetchReq)
      next_state.physAddr = {effPage, fetchPc[`PPM_OFFSET_WIDTH-1:0]};
    if (selWrite)
      next_state.pageSelect = dataWrite.data[`PPM_PAGE_MSB:`PPM_PAGE_LSB];
    case (stackOp)
      PPM_STK_PUSH:
      begin
        // Overflow drops the oldest level, as a shift stack does
        for (int i = STACK_DEPTH - 1; i > 0; i--)
          next_state.stack[i] = state.stack[i-1];
        next_state.stack[0] = stackPushPc;
        if (state.stackCount != 3'(STACK_DEPTH))
          next_state.stackCount = state.stackCount + 3'h1;
      end
      PPM_STK_POP:
      begin
        for (int i = 0; i < STACK_DEPTH - 1; i++)
          next_state.stack[i] = state.stack[i+1];
        next_state.stack[STACK_DEPTH-1] = '0;
        if (state.stackCount != 3'h0)
          next_state.stackCount = state.stackCount - 3'h1;
      end
      default:
      begin
        next_state.stackCount = state.stackCount;
      end
    endcase
  end

  // Register; page select gets zero only to avoid X, software must still write it
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      state <= '0;
    else
      state <= next_state;
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign memAddr = state.physAddr;
  assign memValid = state.fetchValid;
  assign vectorHit = state.fetchValid && (state.physAddr[`PPM_OFFSET_WIDTH-1:4] == 7'h7f)
    && (state.physAddr[`PPM_PHYS_WIDTH-1:`PPM_OFFSET_WIDTH] == `PPM_STATIC_PAGE);
  assign stackTop = state.stack[0];
  assign stackFull = (state.stackCount == 3'(STACK_DEPTH));
  assign stackEmpty = (state.stackCount == 3'h0);

  // ****************************************
  // Assertions
  // ****************************************
  property p_upper_static;
    @(posedge clk) disable iff (!reset_n)
    fetchReq && fetchPc[11] |=> memValid && memAddr[12:11] == 2'h1;
  endproperty
  a_upper_static: assert property (p_upper_static) else $error("upper fetch not static");

  property p_lower_sel;
    @(posedge clk) disable iff (!reset_n)
    fetchReq && !fetchPc[11] |=> memAddr[12:11] == $past(state.pageSelect);
  endproperty
  a_lower_sel: assert property (p_lower_sel) else $error("lower fetch wrong page");

  property p_offset;
    @(posedge clk) disable iff (!reset_n)
    fetchReq |=> memAddr[10:0] == $past(fetchPc[10:0]);
  endproperty
  a_offset: assert property (p_offset) else $error("offset bits lost");

  property p_sel_load;
    @(posedge clk) disable iff (!reset_n)
    dataWrite.valid && dataWrite.addr == 8'hca |=> state.pageSelect == $past(dataWrite.data[1:0]);
  endproperty
  a_sel_load: assert property (p_sel_load) else $error("page select not loaded");

  property p_sel_hold;
    @(posedge clk) disable iff (!reset_n)
    !(dataWrite.valid && dataWrite.addr == 8'hca) |=> $stable(state.pageSelect);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("page select changed");

  property p_push_top;
    @(posedge clk) disable iff (!reset_n)
    stackOp == PPM_STK_PUSH ##1 stackOp == PPM_STK_NONE |-> stackTop == $past(stackPushPc);
  endproperty
  a_push_top: assert property (p_push_top) else $error("push value lost");

  property p_count_max;
    @(posedge clk) disable iff (!reset_n)
    state.stackCount <= 3'h6;
  endproperty
  a_count_max: assert property (p_count_max) else $error("stack count over six");

  property p_vector;
    @(posedge clk) disable iff (!reset_n)
    fetchReq && fetchPc[11:4] == 8'hff |=> vectorHit;
  endproperty
  a_vector: assert property (p_vector) else $error("vector fetch missed");

  // Answer timing: exactly one valid per fetch, one cycle later
  property p_valid_follow;
    @(posedge clk) disable iff (!reset_n)
    fetchReq |=> memValid;
  endproperty
  a_valid_follow: assert property (p_valid_follow) else $error("fetch without valid");

  property p_valid_idle;
    @(posedge clk) disable iff (!reset_n)
    !fetchReq |=> !memValid;
  endproperty
  a_valid_idle: assert property (p_valid_idle) else $error("valid without fetch");

  // Address must stand between fetches, the array may sample it late
  property p_addr_hold;
    @(posedge clk) disable iff (!reset_n)
    !fetchReq |=> $stable(memAddr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved while idle");

  // Lower window aimed at page 1 lands on the cells of the upper half
  property p_static_alias;
    @(posedge clk) disable iff (!reset_n)
    fetchReq && !fetchPc[11] && state.pageSelect == 2'h1 |=> memAddr[12:11] == 2'h1;
  endproperty
  a_static_alias: assert property (p_static_alias) else $error("alias page wrong");

  property p_vector_page;
    @(posedge clk) disable iff (!reset_n)
    vectorHit |-> memAddr[12:11] == 2'h1 && memAddr[10:4] == 7'h7f;
  endproperty
  a_vector_page: assert property (p_vector_page) else $error("vector flag off page");

  // Stack edges: pop exposes the next level, full and empty saturate
  property p_pop_top;
    @(posedge clk) disable iff (!reset_n)
    stackOp == PPM_STK_POP && state.stackCount > 3'h1 |=> stackTop == $past(state.stack[1]);
  endproperty
  a_pop_top: assert property (p_pop_top) else $error("pop lost next level");

  property p_full_push;
    @(posedge clk) disable iff (!reset_n)
    stackFull && stackOp == PPM_STK_PUSH |=> stackFull;
  endproperty
  a_full_push: assert property (p_full_push) else $error("full push changed depth");

  property p_empty_pop;
    @(posedge clk) disable iff (!reset_n)
    stackEmpty && stackOp == PPM_STK_POP |=> stackEmpty;
  endproperty
  a_empty_pop: assert property (p_empty_pop) else $error("empty pop changed depth");

  c_static_lower: cover property (@(posedge clk) disable iff (!reset_n)
    fetchReq && !fetchPc[11] && state.pageSelect == 2'h1);
  c_page3: cover property (@(posedge clk) disable iff (!reset_n)
    fetchReq && !fetchPc[11] && state.pageSelect == 2'h3);
  c_full: cover property (@(posedge clk) disable iff (!reset_n) stackFull);
  c_overflow: cover property (@(posedge clk) disable iff (!reset_n)
    stackFull && stackOp == PPM_STK_PUSH);
endmodule

// ---- logic/ppm_regs.svh ----
// Constants for the program page mapper: register offset, fields, vector map.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PPM_REGS_SVH
`define PPM_REGS_SVH
`define PPM_PAGE_SELECT_ADDR 8'hca
`define PPM_PAGE_LSB 0
`define PPM_PAGE_MSB 1
`define PPM_STATIC_PAGE 2'h1
`define PPM_PC_WIDTH 12
`define PPM_PAGE_BIT 11
`define PPM_OFFSET_WIDTH 11
`define PPM_PHYS_WIDTH 13
`define PPM_STACK_DEPTH 6
`define PPM_IRQ_VEC_LO 12'hff0
`define PPM_IRQ_VEC_HI 12'hff7
`define PPM_NMI_VEC_LO 12'hffc
`define PPM_RESET_VEC_LO 12'hffe
`endif

// ---- tb/ppm_prog_mem.sv ----
// Program memory model fed by the page mapper.
// Assumes memAddr is settled while memValid is high.
`timescale 1ns/1ps
`include "ppm_regs.svh"
module ppm_prog_mem
  import ppm_pkg::*;
(
  input wire logic clk,
  input wire logic [`PPM_PHYS_WIDTH-1:0] memAddr,
  input wire logic memValid,
  output logic [7:0] memData
);
  // Byte pattern per cell; 13 bits span four 2K pages
  always_ff @(posedge clk)
  begin
    if (memValid)
      memData <= memAddr[7:0] ^ {3'h0, memAddr[12:8]};
  end
endmodule

// ---- tb/ppm_program_page_mapper_tb.sv ----
// Bench for the page mapper: queue of expected memory addresses.
// Assumes inputs change at the falling edge, results settle by then.
`timescale 1ns/1ps
`include "ppm_regs.svh"
module ppm_program_page_mapper_tb;
  import ppm_pkg::*;
  logic clk = 0;
  logic reset_n = 0;
  logic fetchReq = 0;
  ppm_pc_t fetchPc = '0;
  ppm_pc_t stackPushPc = '0;
  ppm_pc_t stackTop;
  ppm_dwrite_t dataWrite = '0;
  ppm_stk_op_t stackOp = PPM_STK_NONE;
  logic [12:0] memAddr;
  logic [12:0] want;
  logic memValid, vectorHit, stackFull, stackEmpty;
  logic [7:0] memData;
  logic memSeen = 0;
  logic [7:0] memPat = '0;
  logic [12:0] expQ[$];
  ppm_page_t pg = '0;
  logic [31:0] seed = 54433;
  logic [31:0] r;
  int error_cnt = 0;
  int compares = 0;

  initial forever #25 clk = ~clk;

  ppm_program_page_mapper ppm_program_page_mapper_i (.clk(clk), .reset_n(reset_n),
    .fetchReq(fetchReq), .fetchPc(fetchPc), .dataWrite(dataWrite), .stackOp(stackOp),
    .stackPushPc(stackPushPc), .memAddr(memAddr), .memValid(memValid),
    .vectorHit(vectorHit), .stackTop(stackTop), .stackFull(stackFull),
    .stackEmpty(stackEmpty));
  ppm_prog_mem ppm_prog_mem_i (.clk(clk), .memAddr(memAddr), .memValid(memValid),
    .memData(memData));

  // ****************
  // Tasks
  // ****************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // One cycle of stimulus; a same-cycle fetch still sees the old page
  task automatic cyc(input logic f, input ppm_pc_t pc, input logic w, input logic [7:0] a,
    input logic [7:0] d, input ppm_stk_op_t op);
    @(negedge clk);
    fetchReq = f;
    fetchPc = pc;
    stackPushPc = pc;
    dataWrite = {w, a, d};
    stackOp = op;
    if (f)
      expQ.push_back({pc[11] ? `PPM_STATIC_PAGE : pg, pc[10:0]});
    if (w && a == `PPM_PAGE_SELECT_ADDR)
      pg = d[1:0];
  endtask

  task automatic results();
    chk(13'(expQ.size()), 0);
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Each answer matched against the oldest note; array byte checked a cycle on
  always @(negedge clk)
  begin
    if (memSeen)
      chk(13'(memData), 13'(memPat));
    memSeen = (memValid === 1'b1);
    if (memValid === 1'b1)
    begin
      chk(13'(expQ.size() != 0), 1);
      want = expQ.pop_front();
      chk(memAddr, want);
      chk(vectorHit, 13'(want[12:11] == 2'h1 && want[10:4] == 7'h7f));
      memPat = want[7:0] ^ {3'h0, want[12:8]};
    end
  end

  // ****************
  // Tests
  // ****************
  initial
  begin
    repeat (16) @(negedge clk);
    reset_n = 1;
    chk(stackEmpty, 1);
    // Upper bits junk on purpose; select written before any low fetch
    for (int p = 0; p < 4; p++)
    begin
      cyc(0, 0, 1, 8'h90, 8'(p), PPM_STK_NONE);
      cyc(0, 0, 1, 8'hca, {6'h2a, 2'(p)}, PPM_STK_NONE);
      cyc(1, 12'h000, 0, 0, 0, PPM_STK_PUSH);
      cyc(1, 12'h7ff, 0, 0, 0, PPM_STK_POP);
      cyc(1, 12'hff0 + 12'(p * 4), 1, 8'hcb, 8'h03, PPM_STK_NONE);
    end
    $display("page test done");
    // Seventh push overflows and drops the oldest level
    for (int i = 0; i < 7; i++)
      cyc(0, 12'h100 + 12'(i), 0, 0, 0, PPM_STK_PUSH);
    cyc(0, 0, 0, 0, 0, PPM_STK_POP);
    chk(stackFull, 1);
    chk(stackTop, 12'h106);
    cyc(0, 0, 0, 0, 0, PPM_STK_NONE);
    chk(stackTop, 12'h105);
    $display("stack test done");
    // Second reset mid-run; select is rewritten before any low fetch
    @(negedge clk);
    reset_n = 0;
    @(negedge clk);
    chk(memValid, 0);
    chk(memAddr, 0);
    chk(stackEmpty, 1);
    chk(stackFull, 0);
    reset_n = 1;
    cyc(0, 0, 1, 8'hca, 8'h03, PPM_STK_NONE);
    $display("reset test done");
    repeat (300)
    begin
      r = xs();
      cyc(r[0], r[12:1], r[13], r[14] ? 8'hca : r[22:15], r[30:23],
        r[31] ? (r[2] ? PPM_STK_PUSH : PPM_STK_POP) : PPM_STK_NONE);
    end
    repeat (3) cyc(0, 0, 0, 0, 0, PPM_STK_NONE);
    $display("random test done");
    results();
  end

  // Run needs about 350 cycles
  initial
  begin
    #(50 * 2000);
    error_cnt++;
    results();
  end
endmodule
